// >>> core/mtc_cfg.svh
// Register offsets, field positions and reset values of the marker trace control block.
`ifndef MTC_CFG_SVH
`define MTC_CFG_SVH

`define MTC_OFS_MODE    4'h0
`define MTC_OFS_FLAGS   4'h1
`define MTC_OFS_PLACE   4'h2
`define MTC_OFS_CTRL    4'h3
`define MTC_OFS_PTRCMD  4'h4
`define MTC_OFS_PPOS    4'h5
`define MTC_OFS_DPOINT  4'h6
`define MTC_OFS_SECPOS  4'h7
`define MTC_OFS_QUERY   4'h8

`define MTC_FLG_SHOW1   0
`define MTC_FLG_SHOW2   1
`define MTC_FLG_HOLD    2
`define MTC_FLG_DIFF    3
`define MTC_PLC_SEC     2
`define MTC_CTL_BW      0
`define MTC_CTL_CPL     1
`define MTC_CTL_REMOTE  2
`define MTC_PTR_P2M     0
`define MTC_PTR_M2P     1

`define MTC_RST_FLAGS   4'h3
`define MTC_POS_W       10
`define MTC_BRIGHT_HI   2'h3
`define MTC_BRIGHT_LO   2'h1
`define MTC_QRY_NONE    3'h4

`endif

// >>> core/mtc_pkg.sv
// Types of the marker trace control block.
package mtc_pkg;
  typedef enum logic [1:0] {MTC_OFF, MTC_SINGLE, MTC_DELTA} mtc_mode_t;
  typedef enum logic [1:0] {MTC_FULL, MTC_TRA, MTC_TRB, MTC_DIFF} mtc_trace_t;
  typedef struct packed {
    logic              wait_q;
    logic [31:0]       rdata_q;
    mtc_mode_t         mode_q;
    logic              tune_marker_q;
    logic              show1_q;
    logic              show2_q;
    logic              hold_q;
    logic              diff_q;
    mtc_trace_t        pri_q;
    mtc_trace_t        sec_q;
    logic              pri_expl_q;
    logic              sec_expl_q;
    logic              bw_q;
    logic              cpl_q;
    logic              remote_q;
    logic              qsel_q;
    logic [9:0]        ppos_q;
    logic [9:0]        dpoint_q;
    logic [9:0]        secpos_q;
    logic              vis_q;
    logic [1:0]        pbright_q;
    logic [1:0]        sbright_q;
  } mtc_state_t;
endpackage

// >>> core/mtc_top.sv
// Marker mode and marker trace placement logic behind an Avalon-MM register slave.
//
// Chosen here: the address map and register access over Avalon-MM.
`timescale 1ns/100ps
`include "mtc_cfg.svh"

// Behaviour
// - Marker mode holds off=0, single=1, delta=2; off after reset.
// - Single or delta forces tune mode to marker; off forces it to frequency.
// - Placement acts on primary unless secondary is named; targets A, B, full, difference.
// - Placing secondary sets delta; placing primary while off sets single.
// - Placement to A, B or difference sets hold; full clears hold.
// - Hold falling moves A/B markers to full; rising moves full markers to default.
// - Default primary is full whenever hold is off.
// - Hold on: B if second view, else difference, else A if first view at first enabling, else B.
// - Provisional B with nothing shown stays B when a trace turns on; only difference moves it.
// - Default secondary follows primary if hold off or primary on difference, else A at first enabling, otherwise B.
// - A is chosen by default only at first enabling of markers.
// - In bandwidth mode one placement moves both markers to the same trace.
// - Markers return to default on return to local while at maximum span.
// - Secondary position is changed only through the remote register path.
// - Markers visible only with digital storage on; primary brighter in delta.
// - Primary position and data point independent unless coupling is on.
// - Pointer commands copy positions without changing the coupling.
// - Difference on sets hold; hold off clears difference.
// - Trace query reports none when off or secondary asked in single mode.
module mtc_top (
  // Clock, reset and clock enable.
  input  wire logic                  SYS_CLK,
  input  wire logic                  ARST_N,
  input  wire logic                  CLK_EN,
  // Avalon-MM slave.
  input  wire logic [5:0]            AVS_ADDRESS,
  input  wire logic                  AVS_READ,
  input  wire logic                  AVS_WRITE,
  input  wire logic [31:0]           AVS_WRITEDATA,
  output logic      [31:0]           AVS_READDATA,
  output logic                       AVS_WAITREQUEST,
  // Instrument status.
  input  wire logic                  DS_ENABLE,
  input  wire logic                  MAX_SPAN,
  // Marker state.
  output logic                       TUNE_MODE_SELECT,
  output mtc_pkg::mtc_mode_t         MARKER_MODE,
  output mtc_pkg::mtc_trace_t        PRI_TRACE,
  output mtc_pkg::mtc_trace_t        SEC_TRACE,
  output logic                       HOLD_FIRST_TRACE,
  output logic                       DIFFERENCE_TRACE,
  output logic [9:0]                 PRI_POS,
  output logic [9:0]                 DATA_POINT,
  output logic [9:0]                 SEC_POS,
  output logic                       MARKER_VISIBLE,
  output logic [1:0]                 PRI_BRIGHT,
  output logic [1:0]                 SEC_BRIGHT
);
  import mtc_pkg::*;

  mtc_state_t s_q;
  mtc_state_t s_d;

  function automatic mtc_trace_t dflt_pri(logic v1, logic v2, logic h, logic d, logic first);
    if (!h)                    dflt_pri = MTC_FULL;
    else if (v2)               dflt_pri = MTC_TRB;
    else if (d)                dflt_pri = MTC_DIFF;
    else if (v1 && first)      dflt_pri = MTC_TRA;
    else                       dflt_pri = MTC_TRB;
  endfunction

  function automatic mtc_trace_t dflt_sec(mtc_trace_t p, logic h, logic first);
    if (!h || p == MTC_DIFF)   dflt_sec = p;
    else if (first)            dflt_sec = MTC_TRA;
    else                       dflt_sec = MTC_TRB;
  endfunction

  logic       req;
  logic       wr_go;
  logic [3:0] widx;
  logic [3:0] nf;
  logic       flags_chg;
  mtc_trace_t arg;
  mtc_trace_t np;
  logic [2:0] qcode;
  logic       pri_set;
  logic       sec_set;

  assign req   = AVS_READ | AVS_WRITE;
  assign wr_go = AVS_WRITE & ~s_q.wait_q;
  assign widx  = AVS_ADDRESS[5:2];
  assign arg   = mtc_trace_t'(AVS_WRITEDATA[1:0]);

  always_comb begin
    s_d = s_q;
    nf = AVS_WRITEDATA[3:0];
    flags_chg = 1'b0;
    np = MTC_FULL;
    pri_set = 1'b0;
    sec_set = 1'b0;
    // One wait cycle per access; the access completes on the edge with wait low.
    s_d.wait_q = ~(req & s_q.wait_q);
    if (wr_go) begin
      unique case (widx)
        `MTC_OFS_MODE: begin
          if (AVS_WRITEDATA[1:0] <= 2'h2) begin
            s_d.mode_q = mtc_mode_t'(AVS_WRITEDATA[1:0]);
            s_d.tune_marker_q = (AVS_WRITEDATA[1:0] != 2'h0);
            if (s_q.mode_q == MTC_OFF && AVS_WRITEDATA[1:0] != 2'h0) begin
              np = dflt_pri(s_q.show1_q, s_q.show2_q, s_q.hold_q, s_q.diff_q, 1'b1);
              s_d.pri_q = np;
              s_d.sec_q = dflt_sec(np, s_q.hold_q, 1'b1);
              s_d.pri_expl_q = 1'b0;
              s_d.sec_expl_q = 1'b0;
            end
          end
        end
        `MTC_OFS_FLAGS: begin
          if (nf[`MTC_FLG_DIFF]) nf[`MTC_FLG_HOLD] = 1'b1;
          if (!nf[`MTC_FLG_HOLD]) nf[`MTC_FLG_DIFF] = 1'b0;
          s_d.show1_q = nf[`MTC_FLG_SHOW1];
          s_d.show2_q = nf[`MTC_FLG_SHOW2];
          s_d.hold_q  = nf[`MTC_FLG_HOLD];
          s_d.diff_q  = nf[`MTC_FLG_DIFF];
          flags_chg = 1'b1;
        end
        `MTC_OFS_PLACE: begin
          if (AVS_WRITEDATA[`MTC_PLC_SEC] || s_q.bw_q) begin
            s_d.sec_q = arg;
            s_d.sec_expl_q = 1'b1;
            sec_set = 1'b1;
          end
          if (!AVS_WRITEDATA[`MTC_PLC_SEC] || s_q.bw_q) begin
            s_d.pri_q = arg;
            s_d.pri_expl_q = 1'b1;
            pri_set = 1'b1;
          end
          if (AVS_WRITEDATA[`MTC_PLC_SEC]) begin
            s_d.mode_q = MTC_DELTA;
          end else if (s_q.mode_q == MTC_OFF) begin
            s_d.mode_q = MTC_SINGLE;
          end
          s_d.tune_marker_q = 1'b1;
          s_d.hold_q = (arg != MTC_FULL);
          if (arg == MTC_FULL) s_d.diff_q = 1'b0;
        end
        `MTC_OFS_CTRL: begin
          s_d.bw_q = AVS_WRITEDATA[`MTC_CTL_BW];
          s_d.cpl_q = AVS_WRITEDATA[`MTC_CTL_CPL];
          s_d.remote_q = AVS_WRITEDATA[`MTC_CTL_REMOTE];
          if (s_q.remote_q && !AVS_WRITEDATA[`MTC_CTL_REMOTE] && MAX_SPAN) begin
            np = dflt_pri(s_q.show1_q, s_q.show2_q, s_q.hold_q, s_q.diff_q, 1'b0);
            s_d.pri_q = np;
            s_d.sec_q = dflt_sec(np, s_q.hold_q, 1'b0);
            s_d.pri_expl_q = 1'b0;
            s_d.sec_expl_q = 1'b0;
          end
        end
        `MTC_OFS_PTRCMD: begin
          if (AVS_WRITEDATA[`MTC_PTR_P2M]) s_d.dpoint_q = s_q.ppos_q;
          if (AVS_WRITEDATA[`MTC_PTR_M2P]) s_d.ppos_q = s_q.dpoint_q;
        end
        `MTC_OFS_PPOS:   s_d.ppos_q = AVS_WRITEDATA[9:0];
        `MTC_OFS_DPOINT: s_d.dpoint_q = AVS_WRITEDATA[9:0];
        `MTC_OFS_SECPOS: s_d.secpos_q = AVS_WRITEDATA[9:0];
        `MTC_OFS_QUERY:  s_d.qsel_q = AVS_WRITEDATA[0];
        default: ;
      endcase
    end
    // Flag writes, and hold edges caused by a placement, move markers in the same step.
    if (flags_chg || (s_q.hold_q != s_d.hold_q)) begin
      np = dflt_pri(s_d.show1_q, s_d.show2_q, s_d.hold_q, s_d.diff_q, 1'b0);
      if (s_q.hold_q && !s_d.hold_q) begin
        if (!pri_set && s_q.pri_q != MTC_DIFF) s_d.pri_q = MTC_FULL;
        if (!sec_set && s_q.sec_q != MTC_DIFF) s_d.sec_q = MTC_FULL;
      end
      if (!s_q.hold_q && s_d.hold_q) begin
        if (!pri_set && s_q.pri_q == MTC_FULL) s_d.pri_q = np;
        if (!sec_set && s_q.sec_q == MTC_FULL) s_d.sec_q = dflt_sec(np, 1'b1, 1'b0);
      end
      if (!s_d.pri_expl_q) s_d.pri_q = np;
      if (!s_d.sec_expl_q) s_d.sec_q = dflt_sec(np, s_d.hold_q, 1'b0);
    end
    if (s_d.cpl_q) s_d.dpoint_q = s_d.ppos_q;
    s_d.vis_q = DS_ENABLE && (s_d.mode_q != MTC_OFF);
    s_d.pbright_q = s_d.vis_q ? `MTC_BRIGHT_HI : 2'h0;
    s_d.sbright_q = (s_d.vis_q && s_d.mode_q == MTC_DELTA) ? `MTC_BRIGHT_LO : 2'h0;
    // Read data is formed in the wait cycle and stands with wait low.
    if (s_q.mode_q == MTC_OFF || (s_q.qsel_q && s_q.mode_q == MTC_SINGLE)) begin
      qcode = `MTC_QRY_NONE;
    end else begin
      qcode = {1'b0, s_q.qsel_q ? s_q.sec_q : s_q.pri_q};
    end
    s_d.rdata_q = 32'h0;
    if (AVS_READ && s_q.wait_q) begin
      unique case (widx)
        `MTC_OFS_MODE:   s_d.rdata_q = {29'h0, s_q.tune_marker_q, s_q.mode_q};
        `MTC_OFS_FLAGS:  s_d.rdata_q = {28'h0, s_q.diff_q, s_q.hold_q, s_q.show2_q, s_q.show1_q};
        `MTC_OFS_PLACE:  s_d.rdata_q = {26'h0, s_q.sec_expl_q, s_q.pri_expl_q, s_q.sec_q,
                                        s_q.pri_q};
        `MTC_OFS_CTRL:   s_d.rdata_q = {29'h0, s_q.remote_q, s_q.cpl_q, s_q.bw_q};
        `MTC_OFS_PPOS:   s_d.rdata_q = {22'h0, s_q.ppos_q};
        `MTC_OFS_DPOINT: s_d.rdata_q = {22'h0, s_q.dpoint_q};
        `MTC_OFS_SECPOS: s_d.rdata_q = {22'h0, s_q.secpos_q};
        `MTC_OFS_QUERY:  s_d.rdata_q = {28'h0, qcode, s_q.qsel_q};
        default:         s_d.rdata_q = 32'h0;
      endcase
    end
  end

  // Waitrequest freezes with the rest of the state, so CLK_EN must stay high
  // through a bus access, or a completed access may be lost.
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s_q <= '0;
      s_q.wait_q <= 1'b1;
      s_q.show1_q <= 1'b1;
      s_q.show2_q <= 1'b1;
    end else if (CLK_EN) begin
      s_q <= s_d;
    end
  end

  assign AVS_READDATA     = s_q.rdata_q;
  assign AVS_WAITREQUEST  = s_q.wait_q;
  assign TUNE_MODE_SELECT = s_q.tune_marker_q;
  assign MARKER_MODE      = s_q.mode_q;
  assign PRI_TRACE        = s_q.pri_q;
  assign SEC_TRACE        = s_q.sec_q;
  assign HOLD_FIRST_TRACE = s_q.hold_q;
  assign DIFFERENCE_TRACE = s_q.diff_q;
  assign PRI_POS          = s_q.ppos_q;
  assign DATA_POINT       = s_q.dpoint_q;
  assign SEC_POS          = s_q.secpos_q;
  assign MARKER_VISIBLE   = s_q.vis_q;
  assign PRI_BRIGHT       = s_q.pbright_q;
  assign SEC_BRIGHT       = s_q.sbright_q;

  logic wr_en;
  assign wr_en = wr_go & CLK_EN;

  mode_code_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    MARKER_MODE != 2'h3) else $error("marker mode holds an illegal code");
  tune_follow_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    wr_en && widx == `MTC_OFS_MODE && AVS_WRITEDATA[1:0] == 2'h0
    |=> !TUNE_MODE_SELECT) else $error("marker off left tune mode on marker");
  sec_delta_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    wr_en && widx == `MTC_OFS_PLACE && AVS_WRITEDATA[`MTC_PLC_SEC]
    |=> MARKER_MODE == MTC_DELTA && SEC_TRACE == $past(arg))
    else $error("secondary placement did not select delta");
  place_hold_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    wr_en && widx == `MTC_OFS_PLACE |=> HOLD_FIRST_TRACE == ($past(arg) != MTC_FULL))
    else $error("placement did not steer the hold flag");
  hold_full_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    !HOLD_FIRST_TRACE && !s_q.pri_expl_q |-> PRI_TRACE == MTC_FULL)
    else $error("default primary off full with hold off");
  diff_hold_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    DIFFERENCE_TRACE |-> HOLD_FIRST_TRACE) else $error("difference on with hold off");
  vis_ds_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    CLK_EN && !DS_ENABLE |=> !MARKER_VISIBLE) else $error("marker shown without storage");
  bright_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    MARKER_MODE == MTC_DELTA && MARKER_VISIBLE |-> PRI_BRIGHT > SEC_BRIGHT)
    else $error("primary not brighter in delta");
  couple_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    s_q.cpl_q |-> DATA_POINT == PRI_POS) else $error("coupled data point drifted");
  bus_wait_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    CLK_EN && req && AVS_WAITREQUEST ##1 CLK_EN && req |-> !AVS_WAITREQUEST)
    else $error("access not answered after one wait cycle");
  // Marker mode, placement, hold-edge, default, local-return, pointer and visibility checks.
  tune_on_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    wr_en && widx == `MTC_OFS_MODE
    && (AVS_WRITEDATA[1:0] == 2'h1 || AVS_WRITEDATA[1:0] == 2'h2)
    |=> TUNE_MODE_SELECT) else $error("marker on left tune mode on frequency");
  mode_keep_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    wr_en && widx == `MTC_OFS_MODE && AVS_WRITEDATA[1:0] == 2'h3 |=> $stable(MARKER_MODE))
    else $error("illegal mode code was taken");
  pri_single_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    wr_en && widx == `MTC_OFS_PLACE && !AVS_WRITEDATA[`MTC_PLC_SEC] && MARKER_MODE == MTC_OFF
    |=> MARKER_MODE == MTC_SINGLE) else $error("primary placement left markers off");
  hold_clear_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    $fell(HOLD_FIRST_TRACE) |-> PRI_TRACE != MTC_TRA && PRI_TRACE != MTC_TRB
    && SEC_TRACE != MTC_TRA && SEC_TRACE != MTC_TRB) else $error("marker left on A or B");
  hold_set_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    $rose(HOLD_FIRST_TRACE) |-> PRI_TRACE != MTC_FULL && SEC_TRACE != MTC_FULL)
    else $error("marker left on full trace");
  def_share_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    !s_q.pri_expl_q && !s_q.sec_expl_q && !HOLD_FIRST_TRACE |-> SEC_TRACE == PRI_TRACE)
    else $error("default secondary apart from primary");
  first_only_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    $changed(PRI_TRACE) && PRI_TRACE == MTC_TRA
    |-> s_q.pri_expl_q || $past(MARKER_MODE) == MTC_OFF)
    else $error("primary put on A by default");
  bw_both_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    wr_en && widx == `MTC_OFS_PLACE && s_q.bw_q |=> PRI_TRACE == SEC_TRACE)
    else $error("bandwidth placement split the markers");
  local_return_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    wr_en && widx == `MTC_OFS_CTRL && s_q.remote_q
    && !AVS_WRITEDATA[`MTC_CTL_REMOTE] && MAX_SPAN
    |=> !s_q.pri_expl_q && PRI_TRACE != MTC_TRA) else $error("markers not returned at local");
  ptr_cpl_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    wr_en && widx == `MTC_OFS_PTRCMD |=> $stable(s_q.cpl_q))
    else $error("pointer command changed the coupling");
  vis_mode_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    MARKER_VISIBLE |-> MARKER_MODE != MTC_OFF) else $error("marker shown while off");
  sec_dark_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    MARKER_MODE != MTC_DELTA |-> SEC_BRIGHT == 2'h0) else $error("secondary lit outside delta");
endmodule

// >>> dv/mtc_host.sv
// Avalon-MM master model standing in for the remote controller.
`timescale 1ns/100ps
module mtc_host (
  // Bus towards the block.
  input  wire logic        clk,
  input  wire logic        waitreq,
  input  wire logic [31:0] rdata,
  output logic      [5:0]  addr,
  output logic             rd,
  output logic             wr,
  output logic      [31:0] wdata,
  // Set when the block never answered.
  output logic             tmo
);
  initial begin
    {addr, rd, wr, wdata, tmo} = '0;
  end
  // All settings, the secondary position too, reach the block only over this bus.
  task automatic xfer(input logic is_wr, input logic [3:0] idx, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    addr  <= {idx, 2'h0};
    wdata <= d;
    wr    <= is_wr;
    rd    <= !is_wr;
    // Wait and read data are taken at the rising edge that ends the access.
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 64);
    q = rdata;
    tmo = tmo | (n >= 64);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
endmodule

// >>> dv/marker_trace_control_tb.sv
// Self-checking bench of the marker trace control block.
`timescale 1ns/100ps
`include "mtc_cfg.svh"
module marker_trace_control_tb;
  import mtc_pkg::*;
  logic       clk = 1'b0, arst_n = 1'b0, ds_en = 1'b0, max_span = 1'b0, clk_en = 1'b1;
  logic [5:0] adr;
  logic       rd, wr, wrq, tmo, tune, hold, diff, vis;
  logic [31:0] wd, rdat, q;
  mtc_mode_t  mode;
  mtc_trace_t pt, st, e;
  logic [9:0] ppos, dpt, spos, r, r2;
  logic [1:0] pbr, sbr, em;
  logic [3:0] f;
  int         mismatches = 0;
  int         num_checks = 0;

  always #2 clk = ~clk;

  mtc_top mtc_top_inst (.SYS_CLK(clk), .ARST_N(arst_n), .CLK_EN(clk_en), .AVS_ADDRESS(adr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_READDATA(rdat),
    .AVS_WAITREQUEST(wrq), .DS_ENABLE(ds_en), .MAX_SPAN(max_span),
    .TUNE_MODE_SELECT(tune), .MARKER_MODE(mode), .PRI_TRACE(pt), .SEC_TRACE(st),
    .HOLD_FIRST_TRACE(hold), .DIFFERENCE_TRACE(diff), .PRI_POS(ppos), .DATA_POINT(dpt),
    .SEC_POS(spos), .MARKER_VISIBLE(vis), .PRI_BRIGHT(pbr), .SEC_BRIGHT(sbr));
  mtc_host mtc_host_inst (.clk(clk), .waitreq(wrq), .rdata(rdat), .addr(adr), .rd(rd),
    .wr(wr), .wdata(wd), .tmo(tmo));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    if (mismatches == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Effects and visibility settle within three cycles of the write.
  task automatic put(input logic [3:0] idx, input logic [31:0] d);
    mtc_host_inst.xfer(1'b1, idx, d, q);
    repeat (3) @(negedge clk);
  endtask
  task automatic do_reset();
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    @(negedge clk);
  endtask
  // Default primary trace once markers are already on, so trace A never comes up.
  function automatic mtc_trace_t dflt(logic s2, logic h, logic d);
    if (!h) return MTC_FULL;
    if (s2) return MTC_TRB;
    return d ? MTC_DIFF : MTC_TRB;
  endfunction

  initial begin
    void'($urandom(12192));
    do_reset();
    chk(mode, MTC_OFF, "mode");
    chk(tune, 1'b0, "tune");
    for (int i = 1; i < 5; i++) begin
      em = (i == 3) ? 2'h2 : 2'(i % 4);
      put(`MTC_OFS_MODE, i % 4);
      mtc_host_inst.xfer(1'b0, `MTC_OFS_MODE, 32'h0, q);
      chk(q, {29'h0, em != 2'h0, em}, "mode reg");
      chk(tune, em != 2'h0, "tune");
    end
    r = 10'($urandom);
    r2 = ~r;
    put(`MTC_OFS_PPOS, r);
    put(`MTC_OFS_DPOINT, r2);
    chk(dpt, r2, "point");
    put(`MTC_OFS_PTRCMD, 32'h1 << `MTC_PTR_P2M);
    chk(dpt, r, "point");
    put(`MTC_OFS_PPOS, r2);
    put(`MTC_OFS_PTRCMD, 32'h1 << `MTC_PTR_M2P);
    chk(ppos, r, "pri pos");
    put(`MTC_OFS_CTRL, 32'h1 << `MTC_CTL_CPL);
    put(`MTC_OFS_PPOS, r2);
    chk(dpt, r2, "coupled point");
    put(`MTC_OFS_SECPOS, r);
    chk(spos, r, "sec pos");
    mtc_host_inst.xfer(1'b0, `MTC_OFS_QUERY, 32'h0, q);
    chk(q[3:1], `MTC_QRY_NONE, "query");
    mtc_host_inst.xfer(1'b0, 4'hF, 32'h0, q);
    chk(q, 32'h0, "unmapped");
    @(posedge clk);
    ds_en <= 1'b1;
    put(`MTC_OFS_MODE, 32'h2);
    chk(vis, 1'b1, "visible");
    chk(pbr, `MTC_BRIGHT_HI, "pri bright");
    chk(sbr, `MTC_BRIGHT_LO, "sec bright");
    put(`MTC_OFS_FLAGS, 32'h8);
    chk(hold, 1'b1, "hold");
    put(`MTC_OFS_FLAGS, 32'h3);
    chk(diff, 1'b0, "diff");
    repeat (24) begin
      f = 4'($urandom);
      f[2] = f[2] | f[3];
      put(`MTC_OFS_FLAGS, f);
      e = dflt(f[1], f[2], f[3]);
      chk(pt, e, "pri trace");
      chk(st, (!f[2] || e == MTC_DIFF) ? e : MTC_TRB, "sec trace");
    end
    @(posedge clk);
    ds_en <= 1'b0;
    repeat (3) @(negedge clk);
    chk(vis, 1'b0, "visible");
    @(posedge clk);
    clk_en <= 1'b0;
    ds_en  <= 1'b1;
    repeat (3) @(negedge clk);
    chk(vis, 1'b0, "frozen visible");
    @(posedge clk);
    clk_en <= 1'b1;
    repeat (2) @(negedge clk);
    chk(vis, 1'b1, "visible");
    put(`MTC_OFS_MODE, 32'h0);
    put(`MTC_OFS_FLAGS, 32'h5);
    put(`MTC_OFS_MODE, 32'h2);
    chk(pt, MTC_TRA, "pri trace");
    chk(st, MTC_TRA, "sec trace");
    do_reset();
    put(`MTC_OFS_PLACE, 32'h2);
    chk(mode, MTC_SINGLE, "mode");
    chk(hold, 1'b1, "hold");
    chk(pt, MTC_TRB, "pri trace");
    put(`MTC_OFS_PLACE, 32'h4);
    chk(mode, MTC_DELTA, "mode");
    chk(hold, 1'b0, "hold");
    chk(st, MTC_FULL, "sec trace");
    chk(pt, MTC_FULL, "pri trace");
    put(`MTC_OFS_PLACE, 32'h1);
    put(`MTC_OFS_PLACE, 32'h6);
    put(`MTC_OFS_FLAGS, 32'h3);
    chk(pt, MTC_FULL, "pri trace");
    chk(st, MTC_FULL, "sec trace");
    put(`MTC_OFS_CTRL, 32'h1 << `MTC_CTL_REMOTE);
    put(`MTC_OFS_PLACE, 32'h1);
    @(posedge clk);
    max_span <= 1'b1;
    put(`MTC_OFS_CTRL, 32'h0);
    chk(pt, MTC_TRB, "pri trace");
    put(`MTC_OFS_CTRL, 32'h1 << `MTC_CTL_BW);
    put(`MTC_OFS_PLACE, 32'h3);
    chk(pt, MTC_DIFF, "pri trace");
    chk(st, MTC_DIFF, "sec trace");
    mtc_host_inst.xfer(1'b0, `MTC_OFS_QUERY, 32'h0, q);
    chk(q[3:1], 3'h3, "query");
    chk(tmo, 1'b0, "bus answer");
    conclude();
  end

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    conclude();
  end
endmodule
